// ==== inc/gsc_pkg.sv ====
// constants shared by the gauge status and control register block
// assumes a 10 MHz system clock and byte-wide register access
package gsc_pkg;
    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SPECIAL = 8'h15;
    localparam logic [7:0] ADDR_CONTROL = 8'h60;
    localparam int ST_CHG_TERM = 7;
    localparam int ST_ACT_EMPTY = 6;
    localparam int ST_STBY_EMPTY = 5;
    localparam int ST_LEARN = 4;
    localparam int ST_UNDERVOLT = 2;
    localparam int ST_POWER_ON = 1;
    localparam int CT_NEG_BLANK = 7;
    localparam int CT_UV_SLEEP = 6;
    localparam int CT_LOW_SLEEP = 5;
    localparam int CT_NET_OP = 4;
    localparam int CT_UV_THRESH = 3;
    localparam int SF_GP_PIN = 0;
    localparam logic [7:0] CONTROL_MASK = 8'hF8;
    localparam logic [7:0] STATUS_RESET = 8'h02;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SPECIAL_RESET = 8'h01;
    localparam logic [7:0] NET_OP_DEFAULT = 8'h33;
    localparam logic [7:0] NET_OP_ALT = 8'h39;
    // ************************************************************
    // thresholds, voltages in mV except the blanking window in uV and the current LSB in nV, capacities in percent
    // ************************************************************
    localparam logic [7:0] CHG_TERM_CLEAR_PCT = 8'h5A;
    localparam logic [7:0] ACT_EMPTY_CLEAR_PCT = 8'h05;
    localparam logic [7:0] STBY_EMPTY_SET_PCT = 8'h0A;
    localparam logic [7:0] STBY_EMPTY_CLEAR_PCT = 8'h0F;
    localparam logic [15:0] UV_LOW_MV = 16'h0992;
    localparam logic [15:0] UV_HIGH_MV = 16'h1324;
    localparam int NEG_BLANK_UV = 25;
    localparam int CURRENT_LSB_NV = 1563;
    localparam int NEG_BLANK_COUNTS = (NEG_BLANK_UV * 1000) / CURRENT_LSB_NV;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int INTERVAL_MS = 3500;
    localparam int INTERVAL_CYCLES = (CLK_HZ / 1000) * INTERVAL_MS;
    localparam int SLEEP_HOLD_MS = 2000;
    localparam int SLEEP_HOLD_CYCLES = (CLK_HZ / 1000) * SLEEP_HOLD_MS;
endpackage

// ==== src/gsc_tick_divider.sv ====
// fixed-interval enable pulse for the gauge processing cycle
// assumes one free-running clock and an asynchronous active-low reset
`timescale 1ns/1ns
module gsc_tick_divider #(
    parameter int CYCLES = 35_000_000
) (
    input wire logic clock,
    input wire logic rst_n,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic tick_nxt;

    // wrap at the last count and pulse for one cycle
    always_comb begin
        tick_nxt = (count_r == LAST);
        count_nxt = tick_nxt ? '0 : count_r + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            tick <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick <= tick_nxt;
        end
    end
endmodule

// ==== src/gsc_hold_timer.sv ====
// pulses once when a qualified level has stood unchanged for CYCLES clocks
// assumes the watched level is already synchronous to the clock
`timescale 1ns/1ns
module gsc_hold_timer #(
    parameter int CYCLES = 20_000_000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic level,
    output logic expired
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic level_r;
    logic expired_nxt;

    // any level change or loss of enable restarts the wait
    always_comb begin
        expired_nxt = 1'b0;
        count_nxt = count_r;
        if (!enable || level != level_r) begin
            count_nxt = '0;
        end else if (count_r == LAST) begin
            expired_nxt = 1'b1;
            count_nxt = count_r + 1'b1;
        end else if (count_r < LAST) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            level_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            count_r <= count_nxt;
            level_r <= level;
            expired <= expired_nxt;
        end
    end
endmodule

// ==== src/gsc_regs.sv ====
// status, control and special-feature registers of the fuel gauge
// assumes a serial bus engine presents byte reads and writes, and that
// measurement results and thresholds arrive from the measurement core
//
// Contract
// (RL1) charge-termination flag sets when full condition holds across two average updates
// (RL2) charge-termination flag clears when active relative capacity drops below 90%
// (RL3) active-empty flag sets below active-empty voltage, clears above 5% capacity
// (RL4) standby-empty flag sets below 10%, clears above 15%, with hysteresis
// (RL5) learn flag sets on falling through active-empty voltage under heavy discharge
// (RL6) learn flag clears on full, current going negative, charge write, or sleep
// (RL7) charge count zero clears learn only after voltage fell below active-empty
// (RL8) undervoltage flag sets while voltage sits below the sleep threshold
// (RL9) power-on flag sets at every power-up
// (RL10) undervoltage and power-on flags clear only by host writing zero
// (RL11) other status bits are read-only to the host
// (RL12) control register loads from its nonvolatile copy at power-up
// (RL13) blanking enable drops small negative current readings instead of accumulating
// (RL14) undervoltage sleep enable sleeps on low input and stable bus line
// (RL15) line-low sleep enable sleeps after bus line held low
// (RL16) opcode select picks 33h or 39h for the network-address read
// (RL17) threshold select picks 2.45V or 4.9V sleep threshold
// (RL18) special-feature bit 0 reads back the sensed pin level
// (RL19) writing 0 drives the pin low, writing 1 releases it
// (RL20) pin release forced at power-up and on sleep entry
// (RL21) flag conditions are evaluated on a 3.5s processing interval
// (RL22) reserved bits read zero and ignore writes
// (RL23) a hardware set beats a host clear in the same cycle
`timescale 1ns/1ns
module gsc_regs #(
    parameter int INTERVAL_CYCLES = gsc_pkg::INTERVAL_CYCLES,
    parameter int SLEEP_HOLD_CYCLES = gsc_pkg::SLEEP_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic nvControlLoad,
    input wire logic [7:0] nvControlData,
    input wire logic [15:0] cellVoltage,
    input wire logic [15:0] senseVoltageInput,
    input wire logic signed [15:0] averageCurrent,
    input wire logic averageCurrentUpdate,
    input wire logic signed [15:0] measuredCurrent,
    input wire logic measuredCurrentValid,
    input wire logic [7:0] remActiveRelCap,
    input wire logic [7:0] remStandbyRelCap,
    input wire logic [15:0] chargeVoltageThreshold,
    input wire logic signed [15:0] minChargeCurrent,
    input wire logic [15:0] activeEmptyVoltage,
    input wire logic signed [15:0] activeEmptyCurrent,
    input wire logic accumulatedChargeZero,
    input wire logic accumulatedChargeLoad,
    input wire logic busLine,
    input wire logic gpPinIn,
    output logic gpPinOut,
    output logic gpPinOe,
    output logic [7:0] gaugeStatus,
    output logic negBlankEnable,
    output logic accumValid,
    output logic signed [15:0] accumSample,
    output logic [7:0] netAddrOpcode,
    output logic [15:0] sleepThresholdMv,
    output logic sleepEnter
);
    // ************************************************************
    // parameter checks and timing helpers
    // ************************************************************
    // the tick spacing check needs two quiet cycles between ticks
    if (INTERVAL_CYCLES < 3 || SLEEP_HOLD_CYCLES < 2) begin : g_bad_param
        $error("interval needs three cycles and sleep hold two");
    end

    logic tick;
    logic uvSleepHit;
    logic lowSleepHit;
    logic [7:0] status_r, status_nxt;
    logic [7:0] control_r, control_nxt;
    logic gpRelease_r, gpRelease_nxt;
    logic chargeWindow_r, chargeWindow_nxt;
    logic aboveVae_r, aboveVae_nxt;
    logic currentNeg_r, currentNeg_nxt;
    logic zeroArmed_r, zeroArmed_nxt;
    logic sleepNow;
    logic belowSleep;
    logic chargeCondOk;
    logic chgSet, learnSet, learnClr;
    logic hostStatusWr, hostControlWr, hostSpecialWr;
    logic blanked;

    // processing interval pulse [RL21]
    gsc_tick_divider #(.CYCLES(INTERVAL_CYCLES)) u_interval (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick)
    );

    // bus line stable at either level while input is low [RL14]
    gsc_hold_timer #(.CYCLES(SLEEP_HOLD_CYCLES)) u_uv_hold (
        .clock(clock),
        .rst_n(rst_n),
        .enable(control_r[gsc_pkg::CT_UV_SLEEP] && belowSleep),
        .level(busLine),
        .expired(uvSleepHit)
    );

    // bus line held low [RL15]
    gsc_hold_timer #(.CYCLES(SLEEP_HOLD_CYCLES)) u_low_hold (
        .clock(clock),
        .rst_n(rst_n),
        .enable(control_r[gsc_pkg::CT_LOW_SLEEP] && !busLine),
        .level(busLine),
        .expired(lowSleepHit)
    );

    // ************************************************************
    // conditions
    // ************************************************************
    // threshold follows the select bit at once, not the registered copy [RL17]
    assign belowSleep = control_r[gsc_pkg::CT_UV_THRESH] ?
        (senseVoltageInput < gsc_pkg::UV_HIGH_MV) : (senseVoltageInput < gsc_pkg::UV_LOW_MV);
    assign sleepNow = uvSleepHit || lowSleepHit; // [RL14] [RL15]
    assign chargeCondOk = (cellVoltage > chargeVoltageThreshold) && (averageCurrent > 16'sh0000)
        && (averageCurrent < minChargeCurrent);
    assign hostStatusWr = regWrEn && regAddr == gsc_pkg::ADDR_STATUS;
    assign hostControlWr = regWrEn && regAddr == gsc_pkg::ADDR_CONTROL;
    assign hostSpecialWr = regWrEn && regAddr == gsc_pkg::ADDR_SPECIAL;
    // small negative readings between -25uV and zero are dropped [RL13]
    assign blanked = control_r[gsc_pkg::CT_NEG_BLANK] && measuredCurrent < 16'sh0000
        && measuredCurrent >= -16'(gsc_pkg::NEG_BLANK_COUNTS);

    // ************************************************************
    // status flags
    // ************************************************************
    // full needs the condition held from one average update to the next [RL1]
    always_comb begin
        chargeWindow_nxt = chargeWindow_r;
        if (averageCurrentUpdate) begin
            chargeWindow_nxt = chargeCondOk;
        end else if (tick && !chargeCondOk) begin
            chargeWindow_nxt = 1'b0;
        end
        chgSet = averageCurrentUpdate && chargeWindow_r && chargeCondOk; // [RL1]
        // falling through the empty voltage under heavy discharge [RL5]
        learnSet = tick && aboveVae_r && cellVoltage < activeEmptyVoltage
            && measuredCurrent < -activeEmptyCurrent;
        aboveVae_nxt = tick ? (cellVoltage > activeEmptyVoltage) : aboveVae_r;
        currentNeg_nxt = tick ? (measuredCurrent < 16'sh0000) : currentNeg_r;
        // zero count only counts once voltage has been below empty [RL7]
        zeroArmed_nxt = zeroArmed_r;
        if (tick && cellVoltage < activeEmptyVoltage) begin
            zeroArmed_nxt = 1'b1;
        end else if (tick && status_r[gsc_pkg::ST_LEARN] == 1'b0) begin
            zeroArmed_nxt = 1'b0;
        end
        learnClr = chgSet || sleepNow || accumulatedChargeLoad // [RL6]
            || (tick && !currentNeg_r && measuredCurrent < 16'sh0000)
            || (accumulatedChargeZero && zeroArmed_r); // [RL7]
    end

    // host touches only the two sticky bits, and only to clear them [RL10] [RL11]
    always_comb begin
        status_nxt = status_r;
        if (hostStatusWr) begin
            if (!regWrData[gsc_pkg::ST_UNDERVOLT]) status_nxt[gsc_pkg::ST_UNDERVOLT] = 1'b0;
            if (!regWrData[gsc_pkg::ST_POWER_ON]) status_nxt[gsc_pkg::ST_POWER_ON] = 1'b0;
        end
        // sets follow the clears so a same-cycle event survives [RL23]
        if (tick && cellVoltage < sleepThresholdMv) begin
            status_nxt[gsc_pkg::ST_UNDERVOLT] = 1'b1; // [RL8]
        end
        if (tick && remActiveRelCap < gsc_pkg::CHG_TERM_CLEAR_PCT) begin
            status_nxt[gsc_pkg::ST_CHG_TERM] = 1'b0; // [RL2]
        end
        if (chgSet) begin
            status_nxt[gsc_pkg::ST_CHG_TERM] = 1'b1; // [RL1]
        end
        if (tick && remActiveRelCap > gsc_pkg::ACT_EMPTY_CLEAR_PCT) begin
            status_nxt[gsc_pkg::ST_ACT_EMPTY] = 1'b0; // [RL3]
        end
        if (tick && cellVoltage < activeEmptyVoltage) begin
            status_nxt[gsc_pkg::ST_ACT_EMPTY] = 1'b1; // [RL3]
        end
        if (tick && remStandbyRelCap > gsc_pkg::STBY_EMPTY_CLEAR_PCT) begin
            status_nxt[gsc_pkg::ST_STBY_EMPTY] = 1'b0; // [RL4]
        end
        if (tick && remStandbyRelCap < gsc_pkg::STBY_EMPTY_SET_PCT) begin
            status_nxt[gsc_pkg::ST_STBY_EMPTY] = 1'b1; // [RL4]
        end
        if (learnClr) status_nxt[gsc_pkg::ST_LEARN] = 1'b0; // [RL6]
        if (learnSet) status_nxt[gsc_pkg::ST_LEARN] = 1'b1; // [RL5]
        status_nxt[3] = 1'b0; // [RL22]
        status_nxt[0] = 1'b0;
    end

    // ************************************************************
    // control and special-feature registers
    // ************************************************************
    // nonvolatile recall at power-up, host edits afterwards [RL12]
    always_comb begin
        control_nxt = control_r;
        if (nvControlLoad) begin
            control_nxt = nvControlData & gsc_pkg::CONTROL_MASK;
        end else if (hostControlWr) begin
            control_nxt = regWrData & gsc_pkg::CONTROL_MASK; // [RL22]
        end
        gpRelease_nxt = gpRelease_r;
        if (sleepNow) begin
            gpRelease_nxt = 1'b1; // [RL20]
        end else if (hostSpecialWr) begin
            gpRelease_nxt = regWrData[gsc_pkg::SF_GP_PIN]; // [RL19]
        end
    end

    // power-on flag comes from the reset constant [RL9]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= gsc_pkg::STATUS_RESET;
            control_r <= gsc_pkg::CONTROL_RESET;
            gpRelease_r <= gsc_pkg::SPECIAL_RESET[gsc_pkg::SF_GP_PIN];
            chargeWindow_r <= 1'b0;
            aboveVae_r <= 1'b0;
            currentNeg_r <= 1'b0;
            zeroArmed_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            control_r <= control_nxt;
            gpRelease_r <= gpRelease_nxt;
            chargeWindow_r <= chargeWindow_nxt;
            aboveVae_r <= aboveVae_nxt;
            currentNeg_r <= currentNeg_nxt;
            zeroArmed_r <= zeroArmed_nxt;
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    logic [7:0] rdData_nxt;
    logic [7:0] netOp_nxt;
    logic [15:0] sleepMv_nxt;

    // read mux; unmapped addresses answer zero
    always_comb begin
        rdData_nxt = regRdData;
        if (regRdEn) begin
            unique case (regAddr)
                gsc_pkg::ADDR_STATUS: rdData_nxt = status_r;
                gsc_pkg::ADDR_CONTROL: rdData_nxt = control_r;
                gsc_pkg::ADDR_SPECIAL: rdData_nxt = {7'h00, gpPinIn}; // [RL18] [RL22]
                default: rdData_nxt = 8'h00;
            endcase
        end
        netOp_nxt = control_r[gsc_pkg::CT_NET_OP] ? gsc_pkg::NET_OP_ALT
            : gsc_pkg::NET_OP_DEFAULT; // [RL16]
        sleepMv_nxt = control_r[gsc_pkg::CT_UV_THRESH] ? gsc_pkg::UV_HIGH_MV
            : gsc_pkg::UV_LOW_MV; // [RL17]
    end

    // every output leaves from a flop; pin drive is low-only, so data stays zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
            gpPinOut <= 1'b0;
            gpPinOe <= 1'b0;
            gaugeStatus <= gsc_pkg::STATUS_RESET;
            negBlankEnable <= 1'b0;
            accumValid <= 1'b0;
            accumSample <= 16'sh0000;
            netAddrOpcode <= gsc_pkg::NET_OP_DEFAULT;
            sleepThresholdMv <= gsc_pkg::UV_LOW_MV;
            sleepEnter <= 1'b0;
        end else begin
            regRdData <= rdData_nxt;
            gpPinOut <= 1'b0;
            gpPinOe <= !gpRelease_nxt; // [RL19]
            gaugeStatus <= status_nxt;
            negBlankEnable <= control_r[gsc_pkg::CT_NEG_BLANK];
            accumValid <= measuredCurrentValid && !blanked; // [RL13]
            accumSample <= measuredCurrent;
            netAddrOpcode <= netOp_nxt;
            sleepThresholdMv <= sleepMv_nxt;
            sleepEnter <= sleepNow;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_full_sets: assert property (chgSet |=> status_r[7]) // [RL1]
        else $error("charge-termination flag missed its set");
    chk_full_clears: assert property (tick && remActiveRelCap < 8'h5A && !chgSet
        |=> !status_r[7]) else $error("charge-termination flag missed its clear"); // [RL2]
    chk_empty_sets: assert property (tick && cellVoltage < activeEmptyVoltage
        |=> status_r[6]) else $error("active-empty flag missed its set"); // [RL3]
    chk_standby_hyst: assert property (tick && remStandbyRelCap >= 8'h0A
        && remStandbyRelCap <= 8'h0F |=> $stable(status_r[5])) // [RL4]
        else $error("standby-empty flag moved inside hysteresis");
    chk_learn_sleep: assert property (sleepNow && !learnSet |=> !status_r[4]) // [RL6]
        else $error("learn flag survived sleep entry");
    chk_uv_sticky: assert property (status_r[2] && !hostStatusWr |=> status_r[2]) // [RL10]
        else $error("undervoltage flag cleared without host");
    chk_pin_sleep: assert property (sleepNow |=> gpRelease_r ##0 !gpPinOe) // [RL20]
        else $error("pin driver active after sleep entry");
    chk_opcode_sel: assert property (hostControlWr && !nvControlLoad |=> ##1
        netAddrOpcode == ($past(regWrData[4], 2) ? 8'h39 : 8'h33)) // [RL16]
        else $error("network opcode does not follow select");
    chk_blank_drop: assert property (measuredCurrentValid && blanked |=> !accumValid) // [RL13]
        else $error("blanked reading was accumulated");
    chk_reserved_zero: assert property (regRdEn && regAddr == 8'h01
        |=> regRdData[3] == 1'b0 && regRdData[0] == 1'b0) // [RL22]
        else $error("reserved status bits read nonzero");
    chk_tick_spacing: assert property (tick |=> !tick [*2]) // [RL21]
        else $error("processing ticks too close");
endmodule

// ==== testbench/gsc_host_model.sv ====
// host-side register bus master for the gauge register block
// assumes one-clock strobes, changed only at falling edges of clock
`timescale 1ns/1ns
module gsc_host_model (
    input wire logic clock,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    // idle bus: strobes low, address and data scrambled so stale values never look valid
    initial begin
        {regWrEn, regRdEn} = 2'h0;
        {regAddr, regWrData} = 16'hA55A;
    end
    // one write, held across the sampling rising edge; a zero acknowledges a sticky flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {regAddr, regWrData, regWrEn} = {a, d, 1'h1};
        @(negedge clock);
        {regWrData, regWrEn} = {~d, 1'h0};
    endtask
    // one read, data taken a cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        {regAddr, regRdEn} = {a, 1'h1};
        @(negedge clock);
        regRdEn = 1'h0;
        d = regRdData;
    endtask
endmodule

// ==== testbench/gsc_regs_test.sv ====
// self-checking bench for the gauge status and control register block
// assumes interval and sleep-hold counts shortened to 8 clocks
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module gsc_regs_test;
    // ****************************
    // signals
    // ****************************
    logic clock, rst_n, regWrEn, regRdEn, nvControlLoad, averageCurrentUpdate, busLine;
    logic measuredCurrentValid, accumulatedChargeZero, accumulatedChargeLoad, gpPinIn;
    logic gpPinOut, gpPinOe, negBlankEnable, accumValid, sleepEnter, extPullUp;
    logic [7:0] regAddr, regWrData, regRdData, nvControlData, remActiveRelCap, remStandbyRelCap;
    logic [7:0] gaugeStatus, netAddrOpcode, rdv, cv;
    logic [15:0] cellVoltage, senseVoltageInput, chargeVoltageThreshold, activeEmptyVoltage;
    logic [15:0] sleepThresholdMv;
    logic signed [15:0] averageCurrent, measuredCurrent, minChargeCurrent, activeEmptyCurrent;
    logic signed [15:0] accumSample;
    int error_cnt, num_checks, n;
    // pin has a weak pulldown; only the bench pull-up lifts it while released
    assign gpPinIn = gpPinOe ? 1'h0 : extPullUp;
    gsc_regs #(.INTERVAL_CYCLES(8), .SLEEP_HOLD_CYCLES(8)) gsc_regs_inst (
        .clock, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .nvControlLoad,
        .nvControlData, .cellVoltage, .senseVoltageInput, .averageCurrent, .averageCurrentUpdate,
        .measuredCurrent, .measuredCurrentValid, .remActiveRelCap, .remStandbyRelCap,
        .chargeVoltageThreshold, .minChargeCurrent, .activeEmptyVoltage, .activeEmptyCurrent,
        .accumulatedChargeZero, .accumulatedChargeLoad, .busLine, .gpPinIn, .gpPinOut, .gpPinOe,
        .gaugeStatus, .negBlankEnable, .accumValid, .accumSample, .netAddrOpcode,
        .sleepThresholdMv, .sleepEnter);
    gsc_host_model gsc_host_model_inst (.clock, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData);
    // ****************************
    // helpers
    // ****************************
    // free-running 100 ns clock
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    function automatic logic [15:0] thr_exp(input logic [7:0] d);
        return d[3] ? gsc_pkg::UV_HIGH_MV : gsc_pkg::UV_LOW_MV;
    endfunction
    function automatic logic [7:0] op_exp(input logic [7:0] d);
        return d[4] ? 8'h39 : 8'h33;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        gsc_host_model_inst.wr(a, d);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        gsc_host_model_inst.rd(a, rdv);
        `CHK(rdv, e)
    endtask
    // polled flags move on interval ticks or average updates, so poll with a bound of a few intervals
    task automatic wait_bit(input int idx, input logic val);
        for (n = 0; n < 32 && gaugeStatus[idx] !== val; n++) @(negedge clock);
        `CHK(gaugeStatus[idx], val)
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************
    // main sequence
    // ****************************
    initial begin
        void'($urandom(75));
        {rst_n, busLine, nvControlLoad, averageCurrentUpdate, measuredCurrentValid} = 5'h08;
        {accumulatedChargeZero, accumulatedChargeLoad, extPullUp, nvControlData} = '0;
        {averageCurrent, measuredCurrent, minChargeCurrent} = {32'h0, 16'h000A};
        {cellVoltage, senseVoltageInput, activeEmptyVoltage} = {32'h0E740E74, 16'h0BB8};
        {chargeVoltageThreshold, activeEmptyCurrent} = {16'h1068, 16'h0064};
        {remActiveRelCap, remStandbyRelCap} = 16'h3232;
        repeat (6) @(negedge clock);
        rst_n = 1'h1;
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h02);
        // released at power-up; with no pull-up the weak pulldown reads low
        `CHK(gpPinOe, 1'h0)
        chk_rd(gsc_pkg::ADDR_SPECIAL, 8'h00);
        chk_rd(gsc_pkg::ADDR_CONTROL, 8'h00);
        chk_rd(8'h00, 8'h00);
        // control from the stored copy or the host, all opcode and threshold choices
        for (int i = 0; i < 6; i++) begin
            cv = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            if (i % 2 == 0) begin
                @(negedge clock);
                {nvControlData, nvControlLoad} = {cv, 1'h1};
                @(negedge clock);
                nvControlLoad = 1'h0;
            end else begin
                wr(gsc_pkg::ADDR_CONTROL, cv);
            end
            chk_rd(gsc_pkg::ADDR_CONTROL, cv & 8'hF8);
            `CHK(netAddrOpcode, op_exp(cv))
            `CHK(sleepThresholdMv, thr_exp(cv))
            `CHK(negBlankEnable, cv[7])
        end
        wr(gsc_pkg::ADDR_CONTROL, 8'h00);
        // ones are ignored; the zero acks undervoltage left by the 4.9V threshold runs
        wr(gsc_pkg::ADDR_STATUS, 8'hFB);
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h02);
        wr(gsc_pkg::ADDR_STATUS, 8'h00);
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h00);
        // low cell sets undervoltage and active-empty; 5% is not enough to clear
        cellVoltage = 16'h07D0;
        wait_bit(2, 1'h1);
        wait_bit(6, 1'h1);
        {cellVoltage, remActiveRelCap} = {16'h0E74, 8'h05};
        repeat (24) @(negedge clock);
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h44);
        remActiveRelCap = 8'h06;
        wait_bit(6, 1'h0);
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h04);
        wr(gsc_pkg::ADDR_STATUS, 8'h00);
        chk_rd(gsc_pkg::ADDR_STATUS, 8'h00);
        // standby hysteresis: set below 10, hold at 15, clear above 15
        remStandbyRelCap = 8'h09;
        wait_bit(5, 1'h1);
        remStandbyRelCap = 8'h0F;
        repeat (24) @(negedge clock);
        `CHK(gaugeStatus[5], 1'h1)
        remStandbyRelCap = 8'h10;
        wait_bit(5, 1'h0);
        // pin drive and sense, reserved bits written as ones
        wr(gsc_pkg::ADDR_SPECIAL, 8'hFE);
        `CHK(gpPinOe, 1'h1)
        `CHK(gpPinOut, 1'h0)
        chk_rd(gsc_pkg::ADDR_SPECIAL, 8'h00);
        extPullUp = 1'h1;
        wr(gsc_pkg::ADDR_SPECIAL, 8'h01);
        `CHK(gpPinOe, 1'h0)
        chk_rd(gsc_pkg::ADDR_SPECIAL, 8'h01);
        // blanking window edge: -5 dropped, -16 kept, -5 kept with blanking off
        for (int i = 0; i < 3; i++) begin
            wr(gsc_pkg::ADDR_CONTROL, (i < 2) ? 8'h80 : 8'h00);
            @(negedge clock);
            {measuredCurrent, measuredCurrentValid} = {(i == 1) ? -16'sd16 : -16'sd5, 1'h1};
            @(negedge clock);
            measuredCurrentValid = 1'h0;
            `CHK(accumValid, i != 0)
            `CHK(accumSample, (i == 1) ? -16'sd16 : -16'sd5)
        end
        // bus line held low with line-low sleep enabled; pin must be released
        wr(gsc_pkg::ADDR_SPECIAL, 8'h00);
        wr(gsc_pkg::ADDR_CONTROL, 8'h20);
        busLine = 1'h0;
        for (n = 0; n < 40 && sleepEnter !== 1'h1; n++) @(negedge clock);
        `CHK(sleepEnter, 1'h1)
        `CHK(gpPinOe, 1'h0)
        chk_rd(gsc_pkg::ADDR_SPECIAL, 8'h01);
        // heavy discharge through empty sets learn; a full charge then clears it
        {measuredCurrent, cellVoltage} = {-16'sd200, 16'h0BB7};
        wait_bit(4, 1'h1);
        {remActiveRelCap, cellVoltage, averageCurrent} = {8'h5A, 16'h1100, 16'sd5};
        repeat (2) begin
            repeat (12) @(negedge clock);
            averageCurrentUpdate = 1'h1;
            @(negedge clock);
            averageCurrentUpdate = 1'h0;
        end
        wait_bit(7, 1'h1);
        `CHK(gaugeStatus[4], 1'h0)
        remActiveRelCap = 8'h59;
        wait_bit(7, 1'h0);
        end_of_test();
    end
endmodule
